// ===== hdl/frame_sync_ctrl.sv
`timescale 1ns/10ps
`include "fsync_defs.svh"
// Overview of operation
// R1: frame alignment happens only while the enable bit is set; default off.
// R2: with validate set, clock input one valid needs pulse input two valid.
// R3: with validate set, clock input three valid needs pulse input four.
// R4: with validate clear, the clock input's own validity decides alone.
// R5: level mode: every rising edge of the frame pulse aligns.
// R6: one-shot mode: only the first pulse after arming aligns.
// R7: the board re-arms by pin high then low, or soft bit clear then set.
// R8: buffered control writes take effect only after an I/O update write.
// R9: arm method zero uses the arm pin, one uses the soft arm bit.
// R10: a set soft arm bit arms after I/O update; next pulse aligns.
// R11: the soft arm bit does nothing unless soft arming is selected.
// R12: unused upper bits of both control registers read zero.
// R13: while disabled, arm events and pulses are ignored entirely.
module frame_sync_ctrl
#(
  parameter int COUNT_W = 8
)
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [13:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ARM_PIN,
  input wire logic PULSE_TWO_PIN,
  input wire logic PULSE_FOUR_PIN,
  input wire logic CLOCK_INPUT_ONE_OK,
  input wire logic PULSE_INPUT_TWO_OK,
  input wire logic CLOCK_INPUT_THREE_OK,
  input wire logic PULSE_INPUT_FOUR_OK,
  input wire logic SELECT_INPUT_THREE,
  output logic CLOCK_INPUT_ONE_VALID,
  output logic CLOCK_INPUT_THREE_VALID,
  output logic ALIGN_STROBE,
  output logic ARMED
);

  if (COUNT_W < 1 || COUNT_W > `FS_STAT_CNT_MAX)
  begin : g_bad_count
    $error("COUNT_W must lie between 1 and 24");
  end

  logic rst_meta_reg;
  logic rst_n_reg;
  logic [11:0] word_idx;
  logic aligned;
  logic hit_enable;
  logic hit_mode;
  logic hit_update;
  logic hit_status;
  logic mapped;
  logic access;
  logic sample;
  logic wr_lane0;
  logic [31:0] rd_data;
  logic staged_enable_reg;
  fsync_pkg::mode_t staged_mode_reg;
  logic active_enable_reg;
  fsync_pkg::mode_t active_mode_reg;
  logic update_pulse_reg;
  fsync_pkg::pins_t pins_s;
  fsync_pkg::pins_t pins_prev_reg;
  logic soft_req;
  logic soft_prev_reg;
  logic pin_arm_event;
  logic soft_arm_event;
  logic arm_event;
  logic edge_two;
  logic edge_four;
  logic pulse_edge;
  logic align_next;
  fsync_pkg::arm_state_t state_reg;
  fsync_pkg::arm_state_t state_next;
  logic [COUNT_W-1:0] align_count_reg;
  logic [1:0] declared;

  // reset arrives asynchronously but is released on our own clock
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  assign word_idx = PADDR[13:2];
  assign aligned = (PADDR[1:0] == 2'h0);
  assign hit_enable = aligned && (word_idx == `FS_IDX_ENABLE);
  assign hit_mode = aligned && (word_idx == `FS_IDX_MODE);
  assign hit_update = aligned && (word_idx == `FS_IDX_UPDATE);
  assign hit_status = aligned && (word_idx == `FS_IDX_STATUS);
  assign mapped = hit_enable | hit_mode | hit_update | hit_status;
  // one wait state: pready rises in the second access cycle
  assign access = PSEL & PENABLE & ~PREADY;
  assign sample = PSEL & PENABLE & PREADY;
  assign wr_lane0 = sample & PWRITE & PSTRB[0] & mapped;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit_enable)
      rd_data[0] = staged_enable_reg; // R12
    else if (hit_mode)
      rd_data[3:0] = staged_mode_reg; // R12
    else if (hit_status)
    begin
      rd_data[`FS_STAT_CNT_LSB +: COUNT_W] = align_count_reg;
      rd_data[3:0] = {state_reg == fsync_pkg::SPENT, ARMED,
                      CLOCK_INPUT_THREE_VALID, CLOCK_INPUT_ONE_VALID};
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end
    else
    begin
      PREADY <= access;
      PSLVERR <= access & ~mapped;
      PRDATA <= (access && !PWRITE && mapped) ? rd_data : 32'h0000_0000;
    end
  end

  // software only ever writes the staged copies
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      staged_enable_reg <= `FS_RST_ENABLE;
      staged_mode_reg <= `FS_RST_MODE;
      update_pulse_reg <= 1'b0;
    end
    else
    begin
      if (wr_lane0 && hit_enable)
        staged_enable_reg <= PWDATA[`FS_EN_BIT]; // R12
      if (wr_lane0 && hit_mode)
        staged_mode_reg <= PWDATA[`FS_MODE_W-1:0]; // R12
      update_pulse_reg <= wr_lane0 & hit_update & PWDATA[`FS_UPDATE_BIT];
    end
  end

  // the logic steers from the active copies, loaded only on update
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      active_enable_reg <= `FS_RST_ENABLE;
      active_mode_reg <= `FS_RST_MODE;
    end
    else if (update_pulse_reg)
    begin
      active_enable_reg <= staged_enable_reg; // R8
      active_mode_reg <= staged_mode_reg; // R8
    end
  end

  pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk(CLOCK),
    .rst_n(rst_n_reg),
    .din({ARM_PIN, PULSE_FOUR_PIN, PULSE_TWO_PIN}),
    .dout(pins_s)
  );

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      pins_prev_reg <= `FS_RST_PINS;
      soft_prev_reg <= 1'b0;
    end
    else
    begin
      pins_prev_reg <= pins_s;
      soft_prev_reg <= soft_req;
    end
  end

  // edges per input, then muxed, so a change of selection is no edge
  assign edge_two = pins_s.pulse_two & ~pins_prev_reg.pulse_two;
  assign edge_four = pins_s.pulse_four & ~pins_prev_reg.pulse_four;
  assign pulse_edge = SELECT_INPUT_THREE ? edge_four : edge_two;

  assign pin_arm_event = ~active_mode_reg.soft_method &
                         pins_prev_reg.arm & ~pins_s.arm; // R9 R7
  // selecting soft arming while the bit already stands also arms
  assign soft_req = active_mode_reg.soft_method &
                    active_mode_reg.soft_arm; // R11
  assign soft_arm_event = soft_req & ~soft_prev_reg; // R10 R7
  assign arm_event = pin_arm_event | soft_arm_event;

  always_comb
  begin
    state_next = state_reg;
    if (!active_enable_reg)
      state_next = fsync_pkg::DISARMED; // R13
    else
    begin
      unique case (state_reg)
        fsync_pkg::DISARMED, fsync_pkg::SPENT:
        begin
          if (arm_event)
            state_next = fsync_pkg::ARMED;
        end
        fsync_pkg::ARMED:
        begin
          // a fresh arm in the same cycle keeps the block armed
          if (active_mode_reg.one_shot && pulse_edge && !arm_event)
            state_next = fsync_pkg::SPENT; // R6
        end
        default:
          state_next = fsync_pkg::DISARMED;
      endcase
    end
  end

  assign align_next = active_enable_reg & pulse_edge &
                      (~active_mode_reg.one_shot |
                       (state_reg == fsync_pkg::ARMED)); // R1 R5 R6

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      state_reg <= fsync_pkg::DISARMED;
      ARMED <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      ARMED <= (state_next == fsync_pkg::ARMED);
    end
  end

  // the count wraps; it only shows that alignments are happening
  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      ALIGN_STROBE <= 1'b0;
      align_count_reg <= '0;
    end
    else
    begin
      ALIGN_STROBE <= align_next;
      if (align_next)
        align_count_reg <= align_count_reg + 1'b1;
    end
  end

  valid_gate #(
    .PAIRS(2)
  ) u_valid_gate (
    .clock_ok({CLOCK_INPUT_THREE_OK, CLOCK_INPUT_ONE_OK}),
    .pulse_ok({PULSE_INPUT_FOUR_OK, PULSE_INPUT_TWO_OK}),
    .validate(active_mode_reg.validate),
    .declared(declared)
  );

  always_ff @(posedge CLOCK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      CLOCK_INPUT_ONE_VALID <= 1'b0;
      CLOCK_INPUT_THREE_VALID <= 1'b0;
    end
    else
    begin
      CLOCK_INPUT_ONE_VALID <= declared[0];
      CLOCK_INPUT_THREE_VALID <= declared[1];
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!rst_n_reg);

  AST_NO_ALIGN_DISABLED: assert property ( // R1
    !active_enable_reg |=> !ALIGN_STROBE)
    else $error("alignment while disabled");

  AST_ONE_NEEDS_TWO: assert property ( // R2
    (active_mode_reg.validate && !PULSE_INPUT_TWO_OK)
    |=> !CLOCK_INPUT_ONE_VALID)
    else $error("input one valid without pulse input two");

  AST_THREE_NEEDS_FOUR: assert property ( // R3
    (active_mode_reg.validate && !PULSE_INPUT_FOUR_OK &&
     CLOCK_INPUT_THREE_OK) |=> !CLOCK_INPUT_THREE_VALID)
    else $error("input three valid without pulse input four");

  AST_OWN_VALIDITY: assert property ( // R4
    !active_mode_reg.validate
    |=> (CLOCK_INPUT_ONE_VALID == $past(CLOCK_INPUT_ONE_OK)) &&
        (CLOCK_INPUT_THREE_VALID == $past(CLOCK_INPUT_THREE_OK)))
    else $error("validity not taken from the input alone");

  AST_LEVEL_EVERY_EDGE: assert property ( // R5
    (active_enable_reg && !active_mode_reg.one_shot && pulse_edge)
    |=> ALIGN_STROBE)
    else $error("level mode missed a frame pulse");

  AST_ONE_SHOT_ONCE: assert property ( // R6
    (ALIGN_STROBE && active_mode_reg.one_shot &&
     !$past(arm_event) && $stable(active_mode_reg))
    |=> !ALIGN_STROBE ##1 (!ALIGN_STROBE || $past(arm_event, 2) ||
                           $past(update_pulse_reg, 2)))
    else $error("one-shot aligned twice");

  AST_UPDATE_HOLDS: assert property ( // R8
    !update_pulse_reg
    |=> $stable(active_mode_reg) && $stable(active_enable_reg))
    else $error("active control changed without update");

  AST_UPDATE_COPIES: assert property ( // R8
    (sample && PWRITE && PSTRB[0] && hit_update && PWDATA[0])
    ##1 1'b1 |=> (active_mode_reg == $past(staged_mode_reg)))
    else $error("update did not copy staged control");

  AST_PIN_ARMS: assert property ( // R9
    (active_enable_reg && !active_mode_reg.soft_method &&
     pins_prev_reg.arm && !pins_s.arm) |=> ARMED)
    else $error("pin release did not arm");

  AST_SOFT_ARMS: assert property ( // R10
    (active_enable_reg && soft_arm_event) |=> ARMED)
    else $error("soft arm did not arm");

  AST_SOFT_IGNORED: assert property ( // R11
    (active_enable_reg && !active_mode_reg.soft_method &&
     !ARMED && !pin_arm_event) |=> !ARMED)
    else $error("armed without selected source");

  AST_RESERVED_ZERO: assert property ( // R12
    (PREADY && !PWRITE && (hit_enable || hit_mode))
    |-> (PRDATA[31:4] == 28'h0000000) &&
        (!hit_enable || PRDATA[3:1] == 3'h0))
    else $error("reserved bits read nonzero");

  AST_DISABLED_DISARMED: assert property ( // R13
    !active_enable_reg |=> !ARMED && !ALIGN_STROBE)
    else $error("armed or aligned while disabled");

  COV_LEVEL_ALIGN: cover property (
    !active_mode_reg.one_shot && ALIGN_STROBE);
  COV_ONE_SHOT_ALIGN: cover property (
    ARMED ##1 !ARMED && ALIGN_STROBE);
  COV_SOFT_ARM: cover property (soft_arm_event && active_enable_reg);
  COV_BUS_ERROR: cover property (PREADY && PSLVERR);

endmodule : frame_sync_ctrl

// ===== common/fsync_defs.svh
`ifndef FSYNC_DEFS_SVH
`define FSYNC_DEFS_SVH

// register indices; byte address is four times the index
`define FS_IDX_ENABLE 12'h640
`define FS_IDX_MODE 12'h641
`define FS_IDX_UPDATE 12'h005
`define FS_IDX_STATUS 12'h642

// field positions
`define FS_EN_BIT 0
`define FS_UPDATE_BIT 0
`define FS_MODE_W 4
`define FS_STAT_CNT_LSB 8
`define FS_STAT_CNT_MAX 24

// reset values
`define FS_RST_ENABLE 1'h0
`define FS_RST_MODE 4'h0
`define FS_RST_PINS 3'h0

// synchroniser depth for board pins
`define FS_SYNC_STAGES 3

`endif

// ===== common/fsync_pkg.sv
package fsync_pkg;

  // field order matches bits [3:0] of the mode and arm register
  typedef struct packed {
    logic validate;
    logic one_shot;
    logic soft_method;
    logic soft_arm;
  } mode_t;

  // board pins after synchronisation
  typedef struct packed {
    logic arm;
    logic pulse_four;
    logic pulse_two;
  } pins_t;

  typedef enum logic [1:0] {
    DISARMED = 2'h0,
    ARMED = 2'h1,
    SPENT = 2'h3
  } arm_state_t;

endpackage : fsync_pkg

// ===== hdl/pin_sync.sv
`timescale 1ns/10ps
`include "fsync_defs.svh"
module pin_sync
#(
  parameter int WIDTH = 3
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pin_sync needs at least one bit");
  end

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    logic meta_reg;
    logic mid_reg;
    logic late_reg;
    // the filtered value moves only once two settled stages agree
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        meta_reg <= 1'b0;
        mid_reg <= 1'b0;
        late_reg <= 1'b0;
        dout[i] <= 1'b0;
      end
      else
      begin
        meta_reg <= din[i];
        mid_reg <= meta_reg;
        late_reg <= mid_reg;
        if (mid_reg == late_reg)
          dout[i] <= late_reg;
      end
    end
  end

endmodule : pin_sync

// ===== hdl/valid_gate.sv
`timescale 1ns/10ps
module valid_gate
#(
  parameter int PAIRS = 2
)
(
  input wire logic [PAIRS-1:0] clock_ok,
  input wire logic [PAIRS-1:0] pulse_ok,
  input wire logic validate,
  output logic [PAIRS-1:0] declared
);

  if (PAIRS < 1)
  begin : g_bad_pairs
    $error("valid_gate needs at least one pair");
  end

  for (genvar i = 0; i < PAIRS; i++)
  begin : g_pair
    // each clock input is paired with the pulse input beside it
    assign declared[i] = clock_ok[i] & (pulse_ok[i] | ~validate); // R2 R3 R4
  end

endmodule : valid_gate

// ===== verif/board_model.sv
`timescale 1ns/10ps
module board_model
(
  input wire logic clk,
  output logic arm_pin,
  output logic pulse_two,
  output logic pulse_four
);
  initial
  begin
    arm_pin = 1'b0;
    pulse_two = 1'b0;
    pulse_four = 1'b0;
  end

  // pulses are held 4 cycles so they clear the pin filter
  task automatic pulse(input logic four);
    @(posedge clk);
    if (four)
      pulse_four <= 1'b1;
    else
      pulse_two <= 1'b1;
    repeat (4) @(posedge clk);
    pulse_two <= 1'b0;
    pulse_four <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : pulse

  // re-arm is pin high and then low
  task automatic arm;
    @(posedge clk);
    arm_pin <= 1'b1;
    repeat (4) @(posedge clk);
    arm_pin <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : arm
endmodule : board_model

// ===== verif/testbench.sv
`timescale 1ns/10ps
`include "fsync_defs.svh"
module testbench;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr, e;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic arm_pin, p_two, p_four, sel3, v_one, v_three, strobe, armed;
  logic [3:0] ok, pstrb;
  int err_total, compares, cyc, ns, n0;
  localparam logic [13:0] A_EN = {`FS_IDX_ENABLE, 2'h0};
  localparam logic [13:0] A_MD = {`FS_IDX_MODE, 2'h0};
  localparam logic [13:0] A_UP = {`FS_IDX_UPDATE, 2'h0};
  localparam logic [13:0] A_ST = {`FS_IDX_STATUS, 2'h0};

  frame_sync_ctrl frame_sync_ctrl_i (.CLOCK(clock), .NRST(nrst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .ARM_PIN(arm_pin), .PULSE_TWO_PIN(p_two),
    .PULSE_FOUR_PIN(p_four), .CLOCK_INPUT_ONE_OK(ok[3]),
    .PULSE_INPUT_TWO_OK(ok[2]), .CLOCK_INPUT_THREE_OK(ok[1]),
    .PULSE_INPUT_FOUR_OK(ok[0]), .SELECT_INPUT_THREE(sel3),
    .CLOCK_INPUT_ONE_VALID(v_one), .CLOCK_INPUT_THREE_VALID(v_three),
    .ALIGN_STROBE(strobe), .ARMED(armed));
  board_model board_model_i (.clk(clock), .arm_pin(arm_pin),
    .pulse_two(p_two), .pulse_four(p_four));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (strobe === 1'b1)
      ns <= ns + 1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // pready is judged as the edge samples it; release only after that edge
  task automatic apb(input logic w, input logic [13:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic upd;
    wr(A_UP, 32'h00000001);
  endtask : upd

  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  task automatic t_regs;
    apb(1'b0, A_EN, 32'h0);
    chk("enable reset", q, 32'h00000000);
    apb(1'b0, A_MD, 32'h0);
    chk("mode reset", q, 32'h00000000);
    wr(A_EN, 32'hFFFFFFFF);
    apb(1'b0, A_EN, 32'h0);
    chk("enable upper", q, 32'h00000001);
    wr(A_MD, 32'hFFFFFFFF);
    apb(1'b0, A_MD, 32'h0);
    chk("mode upper", q, 32'h0000000F);
    pstrb <= 4'hE;
    wr(A_EN, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, A_EN, 32'h0);
    chk("lane0 off", q, 32'h00000001);
    apb(1'b0, 14'h0100, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h00000001);
    chk("unmapped data", q, 32'h00000000);
    wr(A_EN, 32'h0);
    wr(A_MD, 32'h0);
    upd();
    $display("test regs done");
  endtask : t_regs

  task automatic t_level;
    n0 = ns;
    board_model_i.pulse(1'b0);
    board_model_i.arm();
    chk("disabled strobes", ns - n0, 0);
    chk("disabled armed", armed, 1'b0);
    wr(A_EN, 32'h1);
    board_model_i.pulse(1'b0);
    chk("staged strobes", ns - n0, 0);
    upd();
    board_model_i.pulse(1'b0);
    board_model_i.pulse(1'b0);
    chk("level strobes", ns - n0, 2);
    sel3 <= 1'b1;
    board_model_i.pulse(1'b1);
    board_model_i.pulse(1'b0);
    chk("pair three strobes", ns - n0, 3);
    sel3 <= 1'b0;
    $display("test level done");
  endtask : t_level

  task automatic t_valid;
    for (int v = 0; v < 2; v++)
    begin
      wr(A_MD, v ? 32'h8 : 32'h0);
      upd();
      for (int i = 0; i < 16; i++)
      begin
        ok <= i[3:0];
        settle();
        chk("one valid", v_one, ok[3] & (ok[2] | !v));
        chk("three valid", v_three, ok[1] & (ok[0] | !v));
      end
    end
    $display("test valid done");
  endtask : t_valid

  task automatic t_soft;
    wr(A_MD, 32'h6);
    upd();
    wr(A_MD, 32'h7);
    upd();
    settle();
    chk("soft armed", armed, 1'b1);
    n0 = ns;
    board_model_i.pulse(1'b0);
    chk("spent armed", armed, 1'b0);
    board_model_i.pulse(1'b0);
    chk("one shot strobes", ns - n0, 1);
    wr(A_MD, 32'h6);
    upd();
    wr(A_MD, 32'h7);
    upd();
    board_model_i.pulse(1'b0);
    chk("rearm strobes", ns - n0, 2);
    $display("test soft done");
  endtask : t_soft

  task automatic t_pin;
    wr(A_MD, 32'h5);
    upd();
    settle();
    chk("pin method soft bit", armed, 1'b0);
    n0 = ns;
    board_model_i.pulse(1'b0);
    chk("unarmed strobes", ns - n0, 0);
    board_model_i.arm();
    chk("pin armed", armed, 1'b1);
    board_model_i.pulse(1'b0);
    chk("pin strobes", ns - n0, 1);
    apb(1'b0, A_ST, 32'h0);
    chk("status", q, 32'h0000060B);
    chk("status err", {31'h0, e}, 32'h00000000);
    $display("test pin done");
  endtask : t_pin

  initial
  begin
    nrst = 1'b0;
    {psel, penable, pwrite, sel3} = 4'h0;
    paddr = 14'h0000;
    pwdata = 32'h0;
    ok = 4'h0;
    pstrb = 4'hF;
    {err_total, compares, cyc, ns} = 0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    t_regs();
    t_level();
    t_valid();
    t_soft();
    t_pin();
    close_out();
  end
endmodule : testbench
